// File: hw/bfd_core.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Burst frequency discriminator core
// ----------------------------------------------------------------
module bfd_core #(
    parameter int unsigned BURSTS   = bfd_pkg::BURSTS_DEF,
    parameter int unsigned WIN_LONG = bfd_pkg::WIN_LONG_CYC,
    parameter int unsigned WIN_SHORT = bfd_pkg::WIN_SHORT_CYC
) (
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_rst_b,
    input  wire logic                              i_ce,
    input  wire bfd_pkg::bfd_pins_t                i_pins,
    input  wire bfd_pkg::bfd_fmt_t                 i_adaptive_burst_mode,
    output bfd_pkg::bfd_result_t                   o_result,
    output logic                                   o_window,
    output logic                                   o_capture
);
    import bfd_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int unsigned BCNT_W = $clog2(BURSTS);
    initial begin
        if (BURSTS != 128 && BURSTS != 256)
            $error("BURSTS must be 128 or 256");
        if (WIN_LONG == 0 || WIN_SHORT == 0 || WIN_LONG >= (1 << WIN_W) || WIN_SHORT >= (1 << WIN_W))
            $error("window length out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WINDOW,
        ST_WAIT_END,
        ST_CLEAR
    } bfd_state_t;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;

    bfd_sync #(.W(3)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_ce      (i_ce),
        .i_async   ({i_pins.burst_gate, i_pins.ref_clk_in, i_pins.sig_clk_in}),
        .o_level   (pin_lvl),
        .o_rise    (pin_rise)
    );

    wire gate_rise = pin_rise[2];
    wire gate_lvl  = pin_lvl[2];
    wire ref_edge  = pin_rise[1];
    wire sig_edge  = pin_rise[0];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bfd_state_t         state_r;
    bfd_state_t         state_nxt;
    logic [WIN_W-1:0]   win_cnt_r;
    logic [BCNT_W-1:0]  burst_cnt_r;
    logic [CNT_W-1:0]   ref_cnt_r;
    logic [CNT_W-1:0]   sig_cnt_r;
    bfd_result_t        result_r;
    logic               window_r;
    logic               capture_r;

    // Format picks window length; sampled at burst start only
    wire [WIN_W-1:0] win_len = (i_adaptive_burst_mode == BFD_FMT_SHORT) ?
                               WIN_W'(WIN_SHORT) : WIN_W'(WIN_LONG);

    wire win_done   = (state_r == ST_WINDOW) && (win_cnt_r == '0);
    wire last_burst = (burst_cnt_r == BCNT_W'(BURSTS - 1));
    wire counting   = (state_r == ST_WINDOW);

    // Signed difference, widened one bit so it never wraps
    function automatic logic signed [CNT_W:0] diff_f(input logic [CNT_W-1:0] s,
                                                      input logic [CNT_W-1:0] r);
        diff_f = $signed({1'b0, s}) - $signed({1'b0, r});
    endfunction

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:     if (gate_rise) state_nxt = ST_WINDOW;
            ST_WINDOW:   if (win_done || !gate_lvl) state_nxt = ST_WAIT_END;
            ST_WAIT_END: if (!gate_lvl) state_nxt = last_burst ? ST_CLEAR : ST_IDLE;
            ST_CLEAR:    state_nxt = ST_IDLE;
        endcase
    end

    // Control and window timer
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r   <= ST_IDLE;
            win_cnt_r <= '0;
            window_r  <= 1'b0;
        end else if (i_ce) begin
            state_r   <= state_nxt;
            window_r  <= (state_nxt == ST_WINDOW);
            // Window ends guard time before burst end
            if (state_r == ST_IDLE && gate_rise)
                win_cnt_r <= win_len - WIN_W'(1);
            else if (counting && win_cnt_r != '0)
                win_cnt_r <= win_cnt_r - WIN_W'(1);
        end
    end

    // Burst counter: wraps after the last burst of a period
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            burst_cnt_r <= '0;
        end else if (i_ce) begin
            if (state_r == ST_CLEAR)
                burst_cnt_r <= '0;
            else if (state_r == ST_WAIT_END && !gate_lvl)
                burst_cnt_r <= burst_cnt_r + BCNT_W'(1);
        end
    end

    // Edge counters; eight bits wrap, ok since only low bits differ
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_cnt_r <= '0;
            sig_cnt_r <= '0;
        end else if (i_ce) begin
            if (state_r == ST_CLEAR) begin
                ref_cnt_r <= '0;
                sig_cnt_r <= '0;
            end else if (counting) begin
                ref_cnt_r <= ref_cnt_r + CNT_W'(ref_edge);
                sig_cnt_r <= sig_cnt_r + CNT_W'(sig_edge);
            end
        end
    end

    // Capture and hold the comparison at period end
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            result_r  <= '0;
            capture_r <= 1'b0;
        end else if (i_ce) begin
            capture_r <= (state_nxt == ST_CLEAR);
            if (state_nxt == ST_CLEAR) begin
                result_r.error <= diff_f(sig_cnt_r, ref_cnt_r);
                result_r.valid <= 1'b1;
            end
        end
    end

    // Held result drives the carrier loop continuously
    assign o_result  = result_r;
    assign o_window  = window_r;
    assign o_capture = capture_r;
endmodule

// File: hw/bfd_pkg.sv
package bfd_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned GUARD_US      = 1000;
    localparam int unsigned BURST_LONG_US = 10_000;
    localparam int unsigned BURST_SHORT_US = 2000;
    localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
    // Window lengths in clock cycles, burst minus guard, rounded down
    localparam int unsigned WIN_LONG_CYC  = (BURST_LONG_US - GUARD_US) * CYC_PER_US;
    localparam int unsigned WIN_SHORT_CYC = (BURST_SHORT_US - GUARD_US) * CYC_PER_US;
    localparam int unsigned WIN_W         = 21;
    localparam int unsigned CNT_W         = 8;
    localparam int unsigned BURSTS_DEF    = 128;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BFD_FMT_LONG,
        BFD_FMT_SHORT
    } bfd_fmt_t;

    typedef struct packed {
        logic burst_gate;
        logic ref_clk_in;
        logic sig_clk_in;
    } bfd_pins_t;

    typedef struct packed {
        logic signed [CNT_W:0] error;
        logic                  valid;
    } bfd_result_t;

endpackage

// File: hw/bfd_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser with rising-edge pulse
// ----------------------------------------------------------------
module bfd_sync #(
    parameter int unsigned W = 3
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    // First stage only feeds second stage
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else if (i_ce) begin
            meta_r <= i_async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_rise  = sync_r & ~prev_r;
endmodule

// File: tb/bfd_core_monitor.sv
`timescale 1ns/1ps
// ----------------------------
// Core port checker
// ----------------------------
module bfd_core_monitor #(
    parameter int unsigned BURSTS    = 128,
    parameter int unsigned WIN_LONG  = 60,
    parameter int unsigned WIN_SHORT = 30
) (
    input wire logic                 i_ref_clk,
    input wire logic                 i_rst_b,
    input wire logic                 i_ce,
    input wire bfd_pkg::bfd_pins_t   i_pins,
    input wire bfd_pkg::bfd_fmt_t    i_adaptive_burst_mode,
    input wire bfd_pkg::bfd_result_t o_result,
    input wire logic                 o_window,
    input wire logic                 o_capture
);
    import bfd_pkg::*;
    int unsigned wrun_r;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // Window run length; a counter, as a long repetition unrolls badly
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) wrun_r <= 0;
        else wrun_r <= o_window ? wrun_r + 1 : 0;
    end
    // Capture, hold and window timing
    a_capture_single: assert property (o_capture |=> !o_capture) else $error("capture too long");
    a_result_held: assert property (!o_capture |-> $stable(o_result)) else $error("result moved");
    a_valid_on_capture: assert property (o_capture |-> o_result.valid) else $error("result not valid");
    a_capture_no_window: assert property (o_capture |-> !o_window) else $error("capture in window");
    a_capture_in_blank: assert property (o_capture |-> !i_pins.burst_gate) else $error("capture in burst");
    a_window_bounded: assert property (o_window |-> wrun_r < WIN_LONG) else $error("window too long");
    a_window_after_gate: assert property ($rose(o_window) |-> $past(i_pins.burst_gate, 2))
        else $error("window without gate");
    a_window_closed_blank: assert property (!i_pins.burst_gate [*6] |-> !o_window)
        else $error("window open in blank");
    a_reset_not_valid: assert property ($rose(i_rst_b) |-> !o_result.valid) else $error("valid at reset");
endmodule

// File: tb/bfd_far.sv
`timescale 1ns/1ps
// ----------------------------
// Burst gate and oscillator source
// ----------------------------
module bfd_far (
    input  wire logic          i_ref_clk,
    input  wire logic          i_go,
    input  wire logic [31:0]   i_len,
    input  wire logic [31:0]   i_nref,
    input  wire logic [31:0]   i_nsig,
    output bfd_pkg::bfd_pins_t o_pins,
    output logic               o_busy
);
    import bfd_pkg::*;
    // Burst of len cycles, blank four times as long; oscillators idle near the
    // window edges so each count is exact, with stray edges in the blank
    initial begin
        o_pins = '0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_ref_clk);
            if (i_go) begin
                o_busy = 1'b1;
                for (int k = 0; k < 5 * i_len; k++) begin
                    @(negedge i_ref_clk);
                    o_pins.burst_gate = k < i_len;
                    o_pins.ref_clk_in = (k >= 6 && k < 6 + 4 * i_nref && k % 4 >= 2) || (k >= i_len + 4 && k % 8 < 4);
                    o_pins.sig_clk_in = k >= 7 && k < 7 + 4 * i_nsig && k % 4 < 2;
                end
                @(posedge i_ref_clk);
                o_busy = 1'b0;
            end
        end
    end
endmodule

// File: tb/tb_burst_frequency_discriminator.sv
`timescale 1ns/1ps
// ----------------------------
// Core against a count model
// ----------------------------
module tb_burst_frequency_discriminator;
    import bfd_pkg::*;
    localparam int WS = 30;
    localparam int WL = 60;
    localparam int NB = 128;
    logic        i_ref_clk;
    logic        i_rst_b;
    logic        go;
    logic        ce;
    logic        busy;
    logic        o_window;
    logic        o_capture;
    bfd_fmt_t    mode;
    bfd_pins_t   pins;
    bfd_result_t o_result;
    int          len, nr, ns, win, rr, sr, bn, caps, wl, error_cnt, n_compared;
    int          seed = 32'h1E3FCA3A;
    bfd_core #(.BURSTS(NB), .WIN_LONG(WL), .WIN_SHORT(WS)) uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_ce(ce), .i_pins(pins), .i_adaptive_burst_mode(mode), .o_result(o_result), .o_window(o_window),
        .o_capture(o_capture));
    bfd_far u_far (.i_ref_clk(i_ref_clk), .i_go(go), .i_len(len), .i_nref(nr),
        .i_nsig(ns), .o_pins(pins), .o_busy(busy));
    // 125 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One burst with random edge counts; held until the source is done
    task automatic burst(input bfd_fmt_t m);
        mode = m;
        win = (m == BFD_FMT_LONG) ? WL : WS;
        len = win + 10;
        nr = 3 + $unsigned($random(seed)) % 4;
        ns = 3 + $unsigned($random(seed)) % 4;
        rr += nr;
        sr += ns;
        bn++;
        go = 1'b1;
        @(negedge i_ref_clk);
        go = 1'b0;
        @(negedge i_ref_clk);
        while (busy) @(negedge i_ref_clk);
        // Freeze the core briefly in the blank; counts must survive it
        ce = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        ce = 1'b1;
    endtask
    // Model of window length and accumulators; 8-bit wrap taken modulo 256
    always @(negedge i_ref_clk) begin
        if (o_window) wl++;
        else if (wl != 0) begin
            chk(wl, win);
            wl = 0;
        end
        if (o_capture) begin
            chk(o_result.error, (sr % 256) - (rr % 256));
            chk(o_result.valid, 1);
            chk(bn % NB, 0);
            caps++;
            rr = 0;
            sr = 0;
        end
    end
    // Watchdog, some 25 percent past the expected run
    initial begin
        #(90000 * 8);
        error_cnt++;
        finish_test;
    end
    initial begin
        i_rst_b = 1'b0;
        go = 1'b0;
        ce = 1'b1;
        mode = BFD_FMT_SHORT;
        repeat (3) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        for (int b = 0; b < 2 * NB; b++) burst(b < NB ? BFD_FMT_SHORT : BFD_FMT_LONG);
        chk(caps, 2);
        finish_test;
    end
endmodule
bind bfd_core bfd_core_monitor #(.BURSTS(BURSTS), .WIN_LONG(WIN_LONG), .WIN_SHORT(WIN_SHORT)) u_mon (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_pins(i_pins),
    .i_adaptive_burst_mode(i_adaptive_burst_mode), .o_result(o_result), .o_window(o_window), .o_capture(o_capture));
